// ### verilog/counter_ctrl_pkg.sv
// Purpose: shared constants and types for the eight bit up counter with controls
// Assumes: APB register access, 32-bit data, one clock
// Notes: offsets are byte addresses
`default_nettype none
package counter_ctrl_pkg;
  // ==========================================================
  // counter geometry
  localparam int COUNT_W = 8;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONES = 8'hFF;
  localparam logic [7:0] COUNT_PRESET_AT = 8'hFE;
  // ==========================================================
  // register map
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int CTRL_SYNC_RESET_BIT = 0;
  localparam int CTRL_HOLD_BIT = 1;
  localparam int CTRL_REPEAT_BIT = 2;
  localparam int CTRL_OUT_DISABLE_BIT = 3;
  localparam int STATUS_STOPPED_BIT = 8;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  // ==========================================================
  // types
  typedef struct packed {
    logic out_disable;
    logic repeat_en;
    logic hold;
    logic sync_reset;
  } ctrl_t;
  typedef enum logic [0:0] {
    RUNNING = 1'b0,
    STOPPED = 1'b1
  } run_state_t;
endpackage
`default_nettype wire

// ### verilog/counter_core.sv
// Purpose: count register with global sync preset and global async clear
// Assumes: async_clear_term_n is glitch free (driven from flops)
// Notes: priority is sync reset, preset, hold, increment
`timescale 1ns/10ps
`default_nettype none
module counter_core #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic async_clear_term_n,
  input wire logic sync_reset,
  input wire logic hold,
  output logic [WIDTH-1:0] count_q
);
  logic [WIDTH-1:0] count_d;
  logic sync_preset_term;

  // ==========================================================
  // next count
  always_comb begin
    sync_preset_term = (count_q[WIDTH-1:1] == {(WIDTH-1){1'b1}}) && !count_q[0];
    if (sync_reset) begin
      count_d = '0;
    end else if (sync_preset_term) begin
      count_d = '1;
    end else if (hold) begin
      count_d = count_q;
    end else begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // register; the clear term acts on every bit at once
  // global async clear
  always_ff @(posedge pclk or negedge async_clear_term_n) begin
    if (!async_clear_term_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/counter_ctrl.sv
// Purpose: eight bit up counter with reset, hold, repeat and output enable over APB
// Assumes: zero wait state APB slave, pclk 50 MHz
// Notes: stop after one pass is an async clear from a flop, so it cannot glitch
`timescale 1ns/10ps
`default_nettype none
module counter_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [counter_ctrl_pkg::COUNT_W-1:0] count_outputs,
  output logic count_outputs_oe
);
  import counter_ctrl_pkg::*;

  ctrl_t ctrl_q;
  ctrl_t ctrl_d;
  run_state_t state_q;
  run_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [COUNT_W-1:0] count;
  logic async_clear_term_n;
  logic setup;
  logic access;
  logic wr_ctrl;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == CTRL_OFFSET) || (a == STATUS_OFFSET);
  endfunction

  // ==========================================================
  // APB slave
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  // unmapped access errors; STATUS writes are dropped quietly
  assign pslverr = access && !addr_mapped(paddr);
  assign wr_ctrl = access && pwrite && pstrb[0] && (paddr == CTRL_OFFSET);
  assign prdata = rdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.sync_reset = pwdata[CTRL_SYNC_RESET_BIT];
      ctrl_d.hold = pwdata[CTRL_HOLD_BIT];
      ctrl_d.repeat_en = pwdata[CTRL_REPEAT_BIT];
      ctrl_d.out_disable = pwdata[CTRL_OUT_DISABLE_BIT];
    end
  end

  // read data is captured in the setup cycle; count may move by one before the access edge
  always_comb begin
    rdata_d = rdata_q;
    if (setup && !pwrite) begin
      rdata_d = 32'h0000_0000;
      if (paddr == CTRL_OFFSET) begin
        rdata_d[CTRL_SYNC_RESET_BIT] = ctrl_q.sync_reset;
        rdata_d[CTRL_HOLD_BIT] = ctrl_q.hold;
        rdata_d[CTRL_REPEAT_BIT] = ctrl_q.repeat_en;
        rdata_d[CTRL_OUT_DISABLE_BIT] = ctrl_q.out_disable;
      end else if (paddr == STATUS_OFFSET) begin
        rdata_d[COUNT_W-1:0] = count;
        rdata_d[STATUS_STOPPED_BIT] = (state_q == STOPPED);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
      rdata_q <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // single pass stop
  // a held all-ones count only waits; it stops once hold is low again
  always_comb begin
    state_d = state_q;
    case (state_q)
      RUNNING: begin
        if (!ctrl_q.repeat_en && !ctrl_q.sync_reset && !ctrl_q.hold && count == COUNT_ONES) begin
          state_d = STOPPED;
        end
      end
      STOPPED: begin
        // restart by sync reset or by asking for repeat
        if (ctrl_q.sync_reset || ctrl_q.repeat_en) begin
          state_d = RUNNING;
        end
      end
      default: begin
        state_d = RUNNING;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RUNNING;
    end else begin
      state_q <= state_d;
    end
  end

  // async clear holds count at zero while stopped
  assign async_clear_term_n = presetn && (state_q != STOPPED);

  // ==========================================================
  // counter
  // sync reset has top priority in the core
  // increments unless reset, preset or hold
  // wrap follows from natural overflow of all ones
  // reset beats hold in the core priority
  // repeat and out_disable stay out of the core, so the wrap is plain overflow
  counter_core #(
    .WIDTH(COUNT_W)
  ) u_core (
    .pclk(pclk),
    .async_clear_term_n(async_clear_term_n),
    .sync_reset(ctrl_q.sync_reset),
    .hold(ctrl_q.hold),
    .count_q(count)
  );

  // ==========================================================
  // count outputs
  // output disable clears count_outputs_oe; count_outputs keeps driving the count
  assign count_outputs = count;
  assign count_outputs_oe = !ctrl_q.out_disable;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // the preset outranks hold, so the hold check leaves out the FE count

  a_clear_all_bits: assert property (
    (state_q == STOPPED) |-> (count == COUNT_ZERO))
    else $error("count not cleared while stopped");

  a_reset_to_zero: assert property (
    ctrl_q.sync_reset |=> (count == COUNT_ZERO))
    else $error("sync reset did not clear count");

  a_count_step: assert property (
    (state_q == RUNNING && !ctrl_q.sync_reset && !ctrl_q.hold && count != COUNT_PRESET_AT
     && !(count == COUNT_ONES && !ctrl_q.repeat_en))
    |=> (count == $past(count) + 8'h01))
    else $error("count did not step by one");

  a_hold_keeps: assert property (
    (state_q == RUNNING && ctrl_q.hold && !ctrl_q.sync_reset && count != COUNT_PRESET_AT)
    |=> $stable(count))
    else $error("hold did not keep count");

  a_repeat_wrap: assert property (
    (ctrl_q.repeat_en && !ctrl_q.sync_reset && !ctrl_q.hold && count == COUNT_ONES)
    |=> (count == COUNT_ZERO) && (state_q == RUNNING))
    else $error("repeat did not wrap to zero");

  a_stop_once: assert property (
    (state_q == RUNNING && !ctrl_q.repeat_en && !ctrl_q.sync_reset && !ctrl_q.hold
     && count == COUNT_ONES) |=> (state_q == STOPPED) ##1 (count == COUNT_ZERO))
    else $error("single pass did not stop");

  a_stop_stays: assert property (
    (state_q == STOPPED && !ctrl_q.repeat_en && !ctrl_q.sync_reset)
    |=> (state_q == STOPPED) && (count == COUNT_ZERO))
    else $error("stopped counter moved");

  a_out_enable: assert property (
    (psel && penable && pwrite && pstrb[0] && paddr == CTRL_OFFSET)
    |=> (count_outputs_oe == !$past(pwdata[CTRL_OUT_DISABLE_BIT])) && (count_outputs == count))
    else $error("output enable wrong");

  a_restart_clean: assert property (
    (state_q == STOPPED && (ctrl_q.sync_reset || ctrl_q.repeat_en))
    |=> (state_q == RUNNING) && (count == COUNT_ZERO))
    else $error("restart did not begin from zero");

  a_preset_ones: assert property (
    (state_q == RUNNING && !ctrl_q.sync_reset && count == COUNT_PRESET_AT)
    |=> (count == COUNT_ONES))
    else $error("preset did not load all ones");

  a_reset_beats_hold: assert property (
    (ctrl_q.sync_reset && ctrl_q.hold) |=> (count == COUNT_ZERO))
    else $error("hold beat sync reset");

  c_wrap: cover property (ctrl_q.repeat_en && count == COUNT_ONES ##1 count == COUNT_ZERO);
  c_stop: cover property (state_q == RUNNING ##1 state_q == STOPPED);
  c_hold_resume: cover property (ctrl_q.hold ##1 !ctrl_q.hold ##1 $changed(count));
  c_float: cover property (!count_outputs_oe);
  c_preset_hold: cover property (ctrl_q.hold && count == COUNT_PRESET_AT ##1 count == COUNT_ONES);
endmodule
`default_nettype wire

// ### verif/counter_ctrl_tb.sv
// Purpose: self-checking bench for the eight bit up counter with controls
// Assumes: zero wait state APB slave, count seen on its own output port
// Notes: expected counts follow from the control bits alone
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, count_outputs_oe, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [3:0] pstrb;
  logic [7:0] count_outputs, held;
  int error_cnt, n_compared, cycles;
  counter_ctrl counter_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_outputs(count_outputs),
    .count_outputs_oe(count_outputs_oe));
  // ==========================================================
  // clock, timeout and verdict
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a full pass is 256 counts; twice that plus bus traffic fits well under the ceiling
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      final_report();
    end
  end
  // ==========================================================
  // bus and sampling helpers
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step();
    @(posedge pclk);
    #1;
  endtask
  task automatic wait_count(input logic [7:0] v);
    int n;
    n = 0;
    while (count_outputs !== v && n < 300) begin
      step();
      n++;
    end
    `CHK("count reached", v, count_outputs)
  endtask
  // ==========================================================
  // scenarios
  task automatic bus_and_enable();
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    `CHK("ctrl reset", 32'h0000_0004, rd_data)
    `CHK("oe reset", 1'b1, count_outputs_oe)
    apb(1'b0, 12'h008, 32'h0, 4'hF);
    `CHK("unmapped err", 1'b1, rd_err)
    `CHK("unmapped data", 32'h0, rd_data)
    apb(1'b1, 12'h004, 32'hFF, 4'hF);
    `CHK("status write err", 1'b0, rd_err)
    apb(1'b1, 12'h000, 32'hC, 4'h0);
    step();
    `CHK("no strobe oe", 1'b1, count_outputs_oe)
    apb(1'b1, 12'h000, 32'hC, 4'hF);
    step();
    `CHK("oe off", 1'b0, count_outputs_oe)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    step();
    `CHK("oe on", 1'b1, count_outputs_oe)
  endtask
  task automatic reset_and_hold();
    apb(1'b1, 12'h000, 32'h5, 4'hF);
    step();
    `CHK("sync reset", 8'h00, count_outputs)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    wait_count(8'h05);
    apb(1'b1, 12'h000, 32'h6, 4'hF);
    step();
    held = count_outputs;
    `CHK("hold point", 8'h08, held)
    repeat (3) step();
    `CHK("held count", held, count_outputs)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    step();
    `CHK("resume", held + 8'h01, count_outputs)
    step();
    `CHK("increment", held + 8'h02, count_outputs)
    // the count is away from zero here, so a hold that won would show
    apb(1'b1, 12'h000, 32'h7, 4'hF);
    step();
    `CHK("reset over hold", 8'h00, count_outputs)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
  endtask
  task automatic wrap_and_stop();
    wait_count(8'hFB);
    // hold lands with the count at FE: the preset must still load all ones
    apb(1'b1, 12'h000, 32'h6, 4'hF);
    step();
    `CHK("preset to ones", 8'hFF, count_outputs)
    step();
    `CHK("held at ones", 8'hFF, count_outputs)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    step();
    `CHK("wrap", 8'h00, count_outputs)
    step();
    `CHK("after wrap", 8'h01, count_outputs)
    apb(1'b1, 12'h000, 32'h0, 4'hF);
    wait_count(8'hFF);
    step();
    `CHK("stop clear", 8'h00, count_outputs)
    repeat (3) step();
    `CHK("stays stopped", 8'h00, count_outputs)
    apb(1'b0, 12'h004, 32'h0, 4'hF);
    `CHK("status stopped", 32'h0000_0100, rd_data)
    apb(1'b1, 12'h000, 32'h4, 4'hF);
    wait_count(8'h02);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    cycles = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    bus_and_enable();
    reset_and_hold();
    wrap_and_stop();
    final_report();
  end
endmodule
`default_nettype wire
